/* File: pkg/lcdrm_pkg.sv */
// Constants for the display RAM mapping block: register map, fields,
// duty encodings, scan geometry and timing counts.
// Assumes one 250 MHz clock and an AHB-Lite register bus.
// Function
// - Row and column outputs keep fixed roles
// - Reverse bit moves address zero to last column
// - Full duty scans 1-40 then 80-41
// - 1/64 and 1/32 duty scan orders, reversible
// - Inversion applied when RAM is written
// - Master drives sync signals, slave follows them
// - Slave keeps drive level generation off
// - RAM holds 320 bits by 80 lines
// - Byte stored with MSB leftmost
// - Two adjacent bits form one pixel
// - Reverse also flips pixel order per group
// - Odd data bits are pixel upper bits
// - Six-bit mode keeps only bits 5 to 0
// - One X address per RAM word
// - Word length affects RAM data only
// - Word length select one means six bits
// - Duty code 11 partial, 10, 01, 00
// - X address wraps after 27h or 35h
package lcdrm_pkg;
  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_XADDR = 8'h08;
  localparam logic [7:0] OFS_YADDR = 8'h0C;
  localparam logic [7:0] OFS_RAMDATA = 8'h10;
  localparam logic [7:0] OFS_PBLOCK = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  // Field positions.
  localparam int CTRL1_REV_BIT = 0;
  localparam int CTRL1_DISP_BIT = 1;
  localparam int CTRL1_STANDBY_BIT_BIT = 2;
  localparam int CTRL2_INC_BIT = 1;
  localparam int CTRL2_DUTY_LSB = 2;
  localparam int CTRL2_WLS_BIT = 5;
  // Reset values.
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  // Duty encodings.
  localparam logic [1:0] DUTY_80 = 2'h0;
  localparam logic [1:0] DUTY_64 = 2'h1;
  localparam logic [1:0] DUTY_32 = 2'h2;
  localparam logic [1:0] DUTY_8 = 2'h3;
  // Geometry.
  localparam int NUM_ROWS = 80;
  localparam int NUM_COLS = 160;
  localparam int LINE_BITS = 320;
  localparam logic [5:0] XWRAP_8 = 6'h27;
  localparam logic [5:0] XWRAP_6 = 6'h35;
  localparam logic [6:0] YLAST = 7'h7F;
  localparam logic [3:0] PB_LAST = 4'h9;
  // Line period in cycles and the latch pulse width.
  localparam logic [7:0] LINE_CYCLES = 8'h40;
  localparam logic [7:0] LATCH_CYCLES = 8'h04;
endpackage : lcdrm_pkg

/* File: rtl/lcdrm_top.sv */
// Display RAM, write-side address and pixel mapping, row scan and
// master/slave line timing, with an AHB-Lite register slave.
// Assumes one clock; sync pins from a master chip are asynchronous.
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module lcdrm_top
  import lcdrm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic master_select_pin,
  input wire logic frame_marker_in,
  output logic frame_marker_out,
  output logic frame_marker_oe,
  input wire logic ac_drive_alternation_in,
  output logic ac_drive_alternation_out,
  output logic ac_drive_alternation_oe,
  input wire logic line_latch_clock_in,
  output logic line_latch_clock_out,
  output logic line_latch_clock_oe,
  output logic oscillator_out_pin_out,
  output logic oscillator_out_pin_oe,
  output logic drive_level_enable,
  output logic [NUM_ROWS-1:0] row_output,
  output logic [LINE_BITS-1:0] column_output
);

  // Bus timing: a transfer is taken at an edge that sees hsel, hready
  // and a non-idle htrans with nothing pending. The next cycle shows
  // hreadyout low, and the edge that ends it performs the write or
  // loads hrdata. hreadyout is high again in the cycle after that. One
  // wait state is always inserted, so the read mux never sits in a
  // combinational path to the pins.
  //
  // The RAM is write-only from the bus. The data port reads as zero,
  // because a read path would need a second port or arbitration
  // against the scan. Software keeps its own copy of the picture.
  //
  // Scan timing: a master steps once every line period, counted by
  // its own line counter. A slave steps on the rising edge of the
  // master's latch pulse, seen about three cycles late through its
  // synchroniser. A slave that sees the frame marker goes back to
  // step zero, so it falls into line with the master within one
  // frame, even if it was enabled in the middle of one.
  //
  // Standby freezes the counters and blanks the panel. The RAM keeps
  // its contents, so the picture comes back when standby is left.
  // Display off blanks the panel, but scanning goes on, so the sync
  // pins stay alive for any slave that is still showing.
  //
  // Limitation: configuration is meant to be written right after
  // reset. A duty change in mid-frame is taken at the next line step,
  // and the frame it lands in may be cut short or run long once.
  //
  // Limitation: rows and columns change only at a line step or when blanked. After a
  // RAM write, the new pixels show on the next visit of that line,
  // never in the middle of one.

  // Number of scanned lines for a duty code.
  function automatic logic [6:0] duty_lines(input logic [1:0] d);
    unique case (d)
      DUTY_80: duty_lines = 7'd80;
      DUTY_64: duty_lines = 7'd64;
      DUTY_32: duty_lines = 7'd32;
      DUTY_8: duty_lines = 7'd8;
    endcase
  endfunction : duty_lines

  // Row driven at scan step s; partial duty takes block row plus s, others: first half counts up from row 0, second
  // half counts down from the last row; reversal plays the non-partial orders backwards.
  function automatic logic [6:0] scan_row(input logic [1:0] d,
      input logic rev, input logic [3:0] pb, input logic [6:0] s);
    logic [6:0] n;
    logic [6:0] h;
    logic [6:0] t;
    n = duty_lines(d);
    h = {1'b0, n[6:1]};
    t = rev ? 7'(n - 7'd1 - s) : s;
    if (d == DUTY_8) begin
      scan_row = 7'({pb, 3'h0} + {4'h0, s[2:0]});
    end else if (t < h) begin
      scan_row = t;
    end else begin
      scan_row = 7'(7'd79 - (t - h));
    end
  endfunction : scan_row

  ////////////////////////////////////////////////////////////////////////
  // Registers and storage.
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl2_reg;
  logic [5:0] x_reg;
  logic [6:0] y_reg;
  logic [3:0] pb_reg;
  logic [LINE_BITS-1:0] line_mem [0:NUM_ROWS-1];
  logic pend_reg;
  logic pend_write_reg;
  logic [7:0] addr_reg;
  logic ms_ff1_reg;
  logic ms_ff2_reg;
  logic [2:0] fm_sync_reg;
  logic [2:0] ll_sync_reg;
  logic [1:0] ac_sync_reg;
  logic [7:0] lcnt_reg;
  logic [6:0] scan_reg;
  logic ac_reg;
  logic osc_reg;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode.
  wire logic accept = hsel & hready & htrans[1];
  wire logic do_write = pend_reg & pend_write_reg;
  wire logic hit_ctrl1 = addr_reg == OFS_CTRL1;
  wire logic hit_ctrl2 = addr_reg == OFS_CTRL2;
  wire logic hit_x = addr_reg == OFS_XADDR;
  wire logic hit_y = addr_reg == OFS_YADDR;
  wire logic hit_ram = addr_reg == OFS_RAMDATA;
  wire logic hit_pb = addr_reg == OFS_PBLOCK;
  wire logic hit_stat = addr_reg == OFS_STATUS;
  wire logic ram_we = do_write & hit_ram;
  // Register writes take the unshifted byte whatever the word length.
  wire logic [7:0] wbyte = hwdata[7:0];
  // Six-bit words are moved up, so both word lengths slice alike and
  // no part-select ever leaves the byte.
  wire logic [7:0] wsh = wls6 ? {wbyte[5:0], 2'h0} : wbyte;

  // Configuration fields.
  wire logic rev = ctrl1_reg[CTRL1_REV_BIT];
  wire logic disp_on = ctrl1_reg[CTRL1_DISP_BIT];
  wire logic standby_bit = ctrl1_reg[CTRL1_STANDBY_BIT_BIT];
  wire logic inc_x = ctrl2_reg[CTRL2_INC_BIT];
  wire logic [1:0] duty = ctrl2_reg[CTRL2_DUTY_LSB +: 2];
  wire logic wls6 = ctrl2_reg[CTRL2_WLS_BIT];
  wire logic is_master = ms_ff2_reg;

  // Read mux; unmapped offsets and the RAM port read as zero.
  wire logic [31:0] rd_word =
    hit_ctrl1 ? {24'h0, ctrl1_reg} :
    hit_ctrl2 ? {24'h0, ctrl2_reg} :
    hit_x ? {26'h0, x_reg} :
    hit_y ? {25'h0, y_reg} :
    hit_pb ? {28'h0, pb_reg} :
    hit_stat ? {16'h0, 7'h0, is_master, 1'b0, scan_reg} : 32'h0;

  ////////////////////////////////////////////////////////////////////////
  // Write-side pixel mapping. Each X address holds one word of four
  // pixels, or three in six-bit mode; bits 7 and 6 are dropped there.
  // Mirroring happens here, so flipping the reverse bit later leaves
  // stored pictures as they were.
  wire logic [8:0] pix_base = wls6 ? 9'({3'h0, x_reg} * 9'd3)
                                    : 9'({3'h0, x_reg} * 9'd4);
  logic [7:0] pix_phys [0:3];
  logic [1:0] pix_pair [0:3];
  logic pix_ok [0:3];
  for (genvar g = 0; g < 4; g++) begin : g_pix
    wire logic [8:0] raw = 9'(pix_base + 9'(g));
    // Left pixel first: the MSB pair lands leftmost.
    assign pix_ok[g] = (raw < 9'd160) && (y_reg < 7'd80) &&
                       (!wls6 || g < 3);
    // Mirror the pixel index but keep each pair intact.
    assign pix_phys[g] = rev ? 8'(9'd159 - raw) : raw[7:0];
    // Odd data bit is the upper pixel bit.
    assign pix_pair[g] = wsh[7 - 2*g -: 2];
  end

  // Next address after a RAM write.
  wire logic [5:0] x_wrap = wls6 ? XWRAP_6 : XWRAP_8;
  wire logic [5:0] x_inc = (x_reg >= x_wrap) ? 6'h0 : 6'(x_reg + 6'h1);
  wire logic [6:0] y_inc = (y_reg == YLAST) ? 7'h0 : 7'(y_reg + 7'h1);

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: every transfer has one wait state, so read data can
  // come straight from a flip-flop.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pend_reg <= 1'b0;
      pend_write_reg <= 1'b0;
      addr_reg <= 8'h0;
      hreadyout <= 1'b1;
      hrdata <= 32'h0;
    end else if (pend_reg) begin
      pend_reg <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= pend_write_reg ? 32'h0 : rd_word;
    end else if (accept) begin
      pend_reg <= 1'b1;
      pend_write_reg <= hwrite;
      addr_reg <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF;
      hreadyout <= 1'b0;
    end
  end

  // Response is always OKAY.
  always_ff @(posedge ref_clk) begin
    hresp <= 1'b0;
  end

  // Control registers.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ctrl1_reg <= CTRL1_RST;
      ctrl2_reg <= CTRL2_RST;
      pb_reg <= 4'h0;
    end else begin
      if (do_write && hit_ctrl1) ctrl1_reg <= wbyte;
      if (do_write && hit_ctrl2) ctrl2_reg <= wbyte;
      if (do_write && hit_pb) pb_reg <= wbyte[3:0];
    end
  end

  // Address registers; a RAM write advances X or Y.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      x_reg <= 6'h0;
      y_reg <= 7'h0;
    end else if (do_write && hit_x) begin
      x_reg <= wbyte[5:0];
    end else if (do_write && hit_y) begin
      y_reg <= wbyte[6:0];
    end else if (ram_we) begin
      if (inc_x) x_reg <= x_inc;
      else y_reg <= y_inc;
    end
  end

  // RAM store; out-of-range pixels and lines are ignored.
  always_ff @(posedge ref_clk) begin
    if (ram_we) begin
      for (int i = 0; i < 4; i++) begin
        if (pix_ok[i]) line_mem[y_reg][pix_phys[i]*2 +: 2] <= pix_pair[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. The first stage feeds only the second.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ms_ff1_reg <= 1'b0;
      ms_ff2_reg <= 1'b0;
      fm_sync_reg <= 3'h0;
      ll_sync_reg <= 3'h0;
      ac_sync_reg <= 2'h0;
    end else begin
      ms_ff1_reg <= master_select_pin;
      ms_ff2_reg <= ms_ff1_reg;
      fm_sync_reg <= {fm_sync_reg[1:0], frame_marker_in};
      ll_sync_reg <= {ll_sync_reg[1:0], line_latch_clock_in};
      ac_sync_reg <= {ac_sync_reg[0], ac_drive_alternation_in};
    end
  end

  // A slave advances on the master's latch edge; a master on its own
  // line counter.
  wire logic slave_step = ll_sync_reg[1] & ~ll_sync_reg[2];
  wire logic slave_first = fm_sync_reg[1];
  wire logic master_step = lcnt_reg == 8'(LINE_CYCLES - 8'h1);
  wire logic [6:0] n_lines = duty_lines(duty);
  wire logic last_line = scan_reg >= 7'(n_lines - 7'h1);
  wire logic running = ~standby_bit;
  wire logic step = running & (is_master ? master_step : slave_step);
  wire logic [6:0] scan_next = is_master ? (last_line ? 7'h0
                                            : 7'(scan_reg + 7'h1))
                             : (slave_first ? 7'h0
                                : 7'(scan_reg + 7'h1));

  // Line timing.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      lcnt_reg <= 8'h0;
      scan_reg <= 7'h0;
      ac_reg <= 1'b0;
    end else if (running) begin
      lcnt_reg <= master_step ? 8'h0 : 8'(lcnt_reg + 8'h1);
      if (step) scan_reg <= scan_next;
      if (step && scan_next == 7'h0 && is_master) ac_reg <= ~ac_reg;
    end
  end

  // Row and line selection for the coming step.
  wire logic [3:0] pb_sel = (pb_reg > PB_LAST) ? PB_LAST : pb_reg;
  wire logic [6:0] row_sel = scan_row(duty, rev, pb_sel, scan_next);
  wire logic [6:0] line_sel = (duty == DUTY_8)
      ? 7'({pb_sel, 3'h0} + {4'h0, scan_next[2:0]}) : scan_next;
  wire logic show = disp_on & ~standby_bit;

  // Outputs change together at each line step, so rows and columns
  // never show a mismatched pair.
  always_ff @(posedge ref_clk) begin
    if (!nrst || !show) begin
      row_output <= '0;
      column_output <= '0;
    end else if (step) begin
      row_output <= NUM_ROWS'(80'h1) << row_sel;
      column_output <= line_mem[line_sel];
    end
  end

  // Sync pins: driven in master mode, released in slave mode.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      frame_marker_out <= 1'b0;
      line_latch_clock_out <= 1'b0;
      ac_drive_alternation_out <= 1'b0;
      frame_marker_oe <= 1'b0;
      line_latch_clock_oe <= 1'b0;
      ac_drive_alternation_oe <= 1'b0;
      oscillator_out_pin_oe <= 1'b0;
      drive_level_enable <= 1'b0;
    end else begin
      frame_marker_out <= running & (scan_reg == 7'h0);
      line_latch_clock_out <= running & (lcnt_reg < LATCH_CYCLES);
      // A slave repeats the master's alternation from its synchroniser.
      ac_drive_alternation_out <= is_master ? ac_reg : ac_sync_reg[1];
      frame_marker_oe <= is_master;
      line_latch_clock_oe <= is_master;
      ac_drive_alternation_oe <= is_master;
      oscillator_out_pin_oe <= is_master;
      drive_level_enable <= is_master & ~standby_bit;
    end
  end

  // Clock handed to the slave: half the core rate.
  always_ff @(posedge ref_clk) begin
    if (!nrst) osc_reg <= 1'b0;
    else osc_reg <= ~osc_reg;
  end
  always_ff @(posedge ref_clk) begin
    oscillator_out_pin_out <= osc_reg & is_master;
  end

endmodule : lcdrm_top

/* File: verif/lcdrm_checker.sv */
// Checker bound to the mapping top: bus, row scan and sync pins.
// Assumes the package constants and one clock domain.
`timescale 1ns/1ps
module lcdrm_checker
  import lcdrm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic master_select_pin,
  input wire logic frame_marker_out,
  input wire logic frame_marker_oe,
  input wire logic ac_drive_alternation_out,
  input wire logic ac_drive_alternation_oe,
  input wire logic line_latch_clock_out,
  input wire logic line_latch_clock_oe,
  input wire logic oscillator_out_pin_oe,
  input wire logic drive_level_enable,
  input wire logic [NUM_ROWS-1:0] row_output
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [NUM_ROWS-1:0] last_row;
  logic [7:0] since_chg;
  // Age of the selected row; it saturates so a long hold never wraps.
  always_ff @(posedge ref_clk) begin
    last_row <= row_output;
    if (!nrst || row_output != last_row) begin
      since_chg <= 8'h01;
    end else if (since_chg != 8'hFF) begin
      since_chg <= since_chg + 8'h01;
    end
  end
  ////////////////////////////////////////
  a_row_onehot:
    assert property ($onehot0(row_output)) else $error("Rows overlap");
  a_bus_wait:
    assert property (hsel && htrans[1] && hreadyout |=> !hreadyout
      ##1 hreadyout) else $error("Wait state wrong");
  a_bus_okay:
    assert property (!hresp) else $error("Response not okay");
  a_reset_idle:
    assert property ($rose(nrst) |-> hreadyout && row_output == '0
      && !frame_marker_oe) else $error("Not idle after reset");
  a_master_pins:
    assert property (master_select_pin [*5] |-> frame_marker_oe
      && line_latch_clock_oe && ac_drive_alternation_oe
      && oscillator_out_pin_oe) else $error("Master pins not driven");
  a_slave_pins:
    assert property (!master_select_pin [*5] |-> !(frame_marker_oe
      || line_latch_clock_oe || ac_drive_alternation_oe))
      else $error("Slave drives sync pins");
  a_slave_levels:
    assert property (!master_select_pin [*5] |-> !drive_level_enable)
      else $error("Slave generates levels");
  a_line_period:
    assert property (master_select_pin && row_output != last_row
      && row_output != '0 && last_row != '0 |-> since_chg == LINE_CYCLES)
      else $error("Line period wrong");
  a_latch_width:
    assert property ($rose(line_latch_clock_out) && line_latch_clock_oe
      |-> line_latch_clock_out [*4] ##1 !line_latch_clock_out)
      else $error("Latch pulse width wrong");
  a_frame_ac:
    assert property ($rose(frame_marker_out) && frame_marker_oe
      && $past(nrst, 3) |-> ac_drive_alternation_out
      != $past(ac_drive_alternation_out, 2)) else $error("No ac toggle");
endmodule : lcdrm_checker

bind lcdrm_top lcdrm_checker u_chk (.ref_clk, .nrst, .hsel, .htrans,
  .hreadyout, .hresp, .master_select_pin, .frame_marker_out,
  .frame_marker_oe, .ac_drive_alternation_out, .ac_drive_alternation_oe,
  .line_latch_clock_out, .line_latch_clock_oe, .oscillator_out_pin_oe,
  .drive_level_enable, .row_output);

/* File: verif/lcdrm_sync_src.sv */
// Model of a master chip's sync outputs, feeding our chip as slave.
// Assumes the bench enables it only while our chip is strapped slave.
`timescale 1ns/1ps
module lcdrm_sync_src
  import lcdrm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic en,
  output logic frame_marker,
  output logic line_latch_clock,
  output logic ac_drive_alternation
);
  logic [7:0] cyc_reg = 8'h00;
  logic [6:0] line_reg = 7'h00;
  logic ac_reg = 1'b0;
  logic tgl_reg = 1'b0;
  // Line and frame counters, parked at zero while our chip is master.
  always @(posedge ref_clk) begin
    tgl_reg <= !tgl_reg;
    if (!en) begin
      cyc_reg <= 8'h00;
      line_reg <= 7'h00;
    end else if (cyc_reg == LINE_CYCLES - 8'h01) begin
      cyc_reg <= 8'h00;
      line_reg <= (line_reg == 7'h4F) ? 7'h00 : line_reg + 7'h01;
      ac_reg <= (line_reg == 7'h4F) ? !ac_reg : ac_reg;
    end else begin
      cyc_reg <= cyc_reg + 8'h01;
    end
  end
  // Released lines toggle, so a chip that still listens sees garbage.
  assign frame_marker = en ? (line_reg == 7'h00) : tgl_reg;
  assign line_latch_clock = en ? (cyc_reg < LATCH_CYCLES) : tgl_reg;
  assign ac_drive_alternation = en ? ac_reg : !tgl_reg;
endmodule : lcdrm_sync_src

/* File: verif/tb_lcd_driver_ram_mapping.sv */
// Bench for the mapping block: RAM writes, scan table, reset, slave.
// Assumes one 250 MHz clock and the sync model on the far side.
`timescale 1ns/1ps
module tb_lcd_driver_ram_mapping import lcdrm_pkg::*;;
  typedef struct packed {logic [1:0] duty; logic rev;
    logic [6:0] step; logic [6:0] row;} lcdrm_scan_s;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b1;
  logic hwrite = 1'b0;
  logic master_select_pin = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, frame_marker_out, frame_marker_oe;
  logic ac_drive_alternation_out, ac_drive_alternation_oe;
  logic line_latch_clock_out, line_latch_clock_oe, drive_level_enable;
  logic p_fm, p_ll, p_ac, fm_w, ll_w, ac_w;
  logic [79:0] row_output;
  logic [319:0] column_output;
  logic [6:0] seen [80];
  logic [19:0] cols;
  int failures = 0;
  int comparisons = 0;
  lcdrm_scan_s tbl [16] = '{'{DUTY_80, 0, 7'h00, 7'h00},
    '{DUTY_80, 0, 7'h27, 7'h27}, '{DUTY_80, 0, 7'h28, 7'h4F},
    '{DUTY_80, 0, 7'h4F, 7'h28}, '{DUTY_80, 1, 7'h00, 7'h28},
    '{DUTY_80, 1, 7'h27, 7'h4F}, '{DUTY_80, 1, 7'h4F, 7'h00},
    '{DUTY_64, 0, 7'h1F, 7'h1F}, '{DUTY_64, 0, 7'h20, 7'h4F},
    '{DUTY_64, 0, 7'h3F, 7'h30}, '{DUTY_64, 1, 7'h00, 7'h30},
    '{DUTY_32, 0, 7'h10, 7'h4F}, '{DUTY_32, 0, 7'h1F, 7'h40},
    '{DUTY_32, 1, 7'h00, 7'h40}, '{DUTY_8, 0, 7'h00, 7'h10},
    '{DUTY_8, 0, 7'h07, 7'h17}};
  // Setup pairs: wrap at the last 8-bit X, then a 6-bit word at X one.
  logic [15:0] setup [10] = '{{OFS_CTRL2, 8'h02}, {OFS_YADDR, 8'h00},
    {OFS_XADDR, 8'h27}, {OFS_RAMDATA, 8'h55}, {OFS_RAMDATA, 8'hE4},
    {OFS_RAMDATA, 8'h80}, {OFS_CTRL2, 8'h22}, {OFS_XADDR, 8'h01},
    {OFS_RAMDATA, 8'hC6}, {OFS_PBLOCK, 8'h02}};
  lcdrm_top DUT (.ref_clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .master_select_pin, .frame_marker_in(fm_w), .frame_marker_out,
    .frame_marker_oe, .ac_drive_alternation_in(ac_w),
    .ac_drive_alternation_out, .ac_drive_alternation_oe,
    .line_latch_clock_in(ll_w), .line_latch_clock_out,
    .line_latch_clock_oe, .oscillator_out_pin_out(),
    .oscillator_out_pin_oe(), .drive_level_enable, .row_output,
    .column_output);
  lcdrm_sync_src partner (.ref_clk, .en(!master_select_pin),
    .frame_marker(p_fm), .line_latch_clock(p_ll),
    .ac_drive_alternation(p_ac));
  // Each sync wire carries whichever party has it enabled.
  assign fm_w = frame_marker_oe ? frame_marker_out : p_fm;
  assign ll_w = line_latch_clock_oe ? line_latch_clock_out : p_ll;
  assign ac_w = ac_drive_alternation_oe ? ac_drive_alternation_out : p_ac;
  always #2 ref_clk = !ref_clk;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // One single transfer; the wait state length is never assumed.
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge ref_clk);
    while (!hreadyout) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (!hreadyout) @(posedge ref_clk);
    q = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  // Samples mid-line from a frame start, one line apart.
  task automatic capture(input int n);
    wait (!fm_w);
    wait (fm_w);
    repeat (32) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      seen[i] = 7'h7F;
      for (int r = 0; r < 80; r++) begin
        if (row_output[r] === 1'b1) seen[i] = r[6:0];
      end
      if (i == 0) cols = {column_output[319:312], column_output[11:0]};
      repeat (64) @(posedge ref_clk);
    end
  endtask : capture
  task automatic rst();
    logic [31:0] q;
    nrst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk("ready", hreadyout, 32'h1);
    chk("outs", (|row_output) | (|column_output), 32'h0);
    bus(1'b0, OFS_CTRL1, 32'h0, q);
    chk("ctrl1", q, {24'h0, CTRL1_RST});
  endtask : rst
  ////////////////////////////////////////
  initial begin
    logic [31:0] q;
    rst();
    foreach (setup[k]) wr(setup[k][15:8], {24'h0, setup[k][7:0]});
    bus(1'b0, OFS_CTRL2, 32'h0, q);
    chk("ctrl2", q, 32'h22);
    bus(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", q, 32'h0);
    for (int i = 0; i < 16; i++) begin
      if (i == 0 || tbl[i][16:14] != tbl[i-1][16:14]) begin
        wr(OFS_CTRL2, {28'h0, tbl[i].duty, 2'h2});
        wr(OFS_CTRL1, {30'h0, 1'b1, tbl[i].rev});
        capture(80);
      end
      chk("row", seen[tbl[i].step], tbl[i].row);
      if (i == 0) chk("cols", cols, 20'h5591B);
      if (i == 4) chk("cols", cols, 20'h5591B);
    end
    wr(OFS_CTRL2, 32'h02);
    wr(OFS_CTRL1, 32'h03);
    wr(OFS_XADDR, 32'h00);
    wr(OFS_RAMDATA, 32'hE4);
    capture(1);
    chk("cols", cols, 20'hE491B);
    chk("lvl", drive_level_enable, 32'h1);
    wr(OFS_CTRL1, 32'h06);
    @(posedge ref_clk);
    chk("standby_bit", {drive_level_enable, |row_output}, 32'h0);
    rst();
    wr(OFS_CTRL1, 32'h02);
    master_select_pin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    capture(2);
    chk("slave", {seen[0], seen[1]}, 32'h0001);
    chk("oe", {frame_marker_oe, drive_level_enable}, 32'h0);
    wr(OFS_CTRL1, 32'h00);
    repeat (2) @(posedge ref_clk);
    chk("off", (|row_output) | (|column_output), 32'h0);
    test_done();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    #360000;
    failures++;
    test_done();
  end
endmodule : tb_lcd_driver_ram_mapping
